// *** hw/copper_ctrl_pkg.sv ***
// constants, types and register map for the copper main control block
package copper_ctrl_pkg;

  // apb register byte addresses
  localparam logic [11:0] COPPER_MAIN_CONTROL_ADDR = 12'h000;
  localparam logic [11:0] LOOPBACK_SPEED_ADDR      = 12'h004;
  localparam logic [11:0] AUX_POWER_DOWN_ADDR      = 12'h008;
  localparam logic [11:0] ACTIVE_STATUS_ADDR       = 12'h00c;

  // field positions in copper_main_control
  localparam int SOFT_RESET_BIT = 15;
  localparam int LOOPBACK_BIT   = 14;
  localparam int SPEED_LSB_BIT  = 13;
  localparam int AN_ENABLE_BIT  = 12;
  localparam int POWER_DOWN_BIT = 11;
  localparam int ISOLATE_BIT    = 10;
  localparam int AN_RESTART_BIT = 9;
  localparam int DUPLEX_BIT     = 8;
  localparam int COL_TEST_BIT   = 7;
  localparam int SPEED_MSB_BIT  = 6;

  // second power-down bit position in the aux register
  localparam int AUX_PD_BIT = 2;

  // hardware reset values
  localparam logic       LOOPBACK_RST  = 1'b0;
  localparam logic       SPEED_LSB_RST = 1'b0;
  localparam logic       SPEED_MSB_RST = 1'b1;
  localparam logic       AN_ENABLE_RST = 1'b1;
  localparam logic       DUPLEX_RST    = 1'b1;
  localparam logic [2:0] LB_SPEED_RST  = 3'h0;

  // speed encodings {msb, lsb}
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // pages touched by a soft reset: 0, 2, 3, 5, 7
  localparam logic [7:0] SOFT_RESET_PAGES = 8'had;

  // length of the self-clearing operations in ref_clk cycles
  localparam logic [7:0] SOFT_RESET_CYCLES = 8'h10;
  localparam logic [7:0] AN_RESTART_CYCLES = 8'h08;

  // index of each self-clearing operation
  localparam int OP_SOFT_RESET = 0;
  localparam int OP_AN_RESTART = 1;

  // operation timer states, gray along idle -> run -> done
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_RUN  = 2'b01,
    OP_DONE = 2'b11
  } op_state_e;

  // configuration that the copper side actually uses
  typedef struct packed {
    logic [1:0] speed;
    logic       duplex;
    logic       an_enable;
    logic       forced_gig;
  } active_cfg_s;

  // one byte of mii-style data with its valid
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } mii_beat_s;

endpackage

// *** hw/self_clear_timer.sv ***
// timer that holds a self-clearing operation busy for a fixed count
`timescale 1ns/1ps
module self_clear_timer (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [7:0] length,
  output logic            busy,
  output logic            done
);
  import copper_ctrl_pkg::*;

  op_state_e  state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;

  // a new start during a run restarts the count, so no request is lost
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      OP_IDLE: begin
        if (start) begin
          state_next = OP_RUN;
          cnt_next   = length;
        end
      end
      OP_RUN: begin
        if (start) begin
          cnt_next = length;
        end else if (cnt_reg <= 8'h01) begin
          state_next = OP_DONE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      OP_DONE: begin
        state_next = start ? OP_RUN : OP_IDLE;
        cnt_next   = length;
      end
      default: begin
        state_next = OP_IDLE;
        cnt_next   = 8'h00;
      end
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= OP_IDLE;
      cnt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign busy = (state_reg == OP_RUN);
  assign done = (state_reg == OP_DONE);
endmodule // self_clear_timer

// *** hw/copper_phy_control_register.sv ***
// copper main control register with apb access and its control effects
// What this block does
// - soft reset touches only pages 0, 2, 3, 5 and 7
// - writing soft reset starts it now; bit clears itself when done
// - loopback returns mac transmit data to receive, drops line link, resets off
// - loopback speed comes from a separate three-bit field
// - forced speed is bit6 msb, bit13 lsb; 00/01/10 = 10/100/1000
// - speed, duplex, negotiation enable apply only on reset, restart, wake
// - negotiation enable resets to one
// - forced gigabit keeps negotiation on, advertising only the chosen duplex
// - forced gigabit ignores the normal advertisement registers
// - power down is the or of two bits; wake needs both zero
// - every wake from power down does soft reset and restart
// - power down loads strap and mode 00x or 11x at hardware reset
// - isolate and collision test read zero and do nothing
// - negotiation restarts after any hardware or soft reset
// - speed msb resets to one, deferred like the lsb
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module copper_phy_control_register (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  // straps
  input  wire logic                       power_down_strap,
  input  wire logic [2:0]                 mode_strap,
  // mac and line data paths
  input  wire copper_ctrl_pkg::mii_beat_s mac_tx,
  input  wire copper_ctrl_pkg::mii_beat_s line_rx,
  output copper_ctrl_pkg::mii_beat_s      mac_rx,
  output copper_ctrl_pkg::mii_beat_s      line_tx,
  // control toward the copper logic
  output logic                            line_link_enable,
  output logic [2:0]                      loopback_speed,
  output logic                            phy_sm_reset,
  output logic [7:0]                      page_reset,
  output logic                            an_restart,
  output logic                            powered_down,
  output copper_ctrl_pkg::active_cfg_s    active_cfg,
  output logic                            adv_override,
  output logic                            adv_gig_full_only,
  output logic                            adv_gig_half_only
);
  import copper_ctrl_pkg::*;

  // written (pending) values
  logic        loopback_reg, loopback_next;
  logic [1:0]  speed_pend_reg, speed_pend_next;
  logic        duplex_pend_reg, duplex_pend_next;
  logic        an_en_pend_reg, an_en_pend_next;
  logic        pd_main_reg, pd_main_next;
  logic        pd_aux_reg, pd_aux_next;
  logic [2:0]  lb_speed_reg, lb_speed_next;
  logic        pd_eff_reg, pd_eff_next;
  logic        hw_rst_done_reg, hw_rst_done_next;
  active_cfg_s active_reg, active_next;
  // registered outputs
  logic        pready_reg, pready_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pslverr_reg, pslverr_next;
  mii_beat_s   mac_rx_reg, mac_rx_next;
  mii_beat_s   line_tx_reg, line_tx_next;
  logic        link_en_reg, link_en_next;
  logic        sm_reset_reg, sm_reset_next;
  logic [7:0]  page_rst_reg, page_rst_next;
  logic        restart_reg, restart_next;
  logic        pd_out_reg, pd_out_next;
  logic [2:0]  adv_reg, adv_next;
  // control strobes
  logic        wr_stb;
  logic        rd_stb;
  logic        main_wr;
  logic        pd_wake;
  logic        soft_rst_trig;
  logic        restart_trig;
  logic [1:0]  op_start;
  logic [1:0]  op_busy;
  logic [7:0]  op_len [2];
  logic [15:0] main_rd;
  logic        mapped;
  logic        strap_pd;

  // writes take effect at the edge where pready is seen high; reads latch prdata at the edge that raises pready
  assign wr_stb  = psel && penable && pready_reg && pwrite;
  assign rd_stb  = psel && penable && !pready_reg && !pwrite;
  assign main_wr = wr_stb && (paddr == COPPER_MAIN_CONTROL_ADDR);
  assign mapped  = (paddr == COPPER_MAIN_CONTROL_ADDR) || (paddr == LOOPBACK_SPEED_ADDR) ||
                   (paddr == AUX_POWER_DOWN_ADDR) || (paddr == ACTIVE_STATUS_ADDR);

  assign strap_pd = power_down_strap && (mode_strap[2:1] == 2'b00 || mode_strap[2:1] == 2'b11);

  // wake: effective power down falls to zero
  assign pd_wake = pd_eff_reg && !pd_eff_next;

  // soft reset starts in the write cycle itself
  assign soft_rst_trig = (main_wr && pwdata[SOFT_RESET_BIT]) || pd_wake;
  // restart follows hardware release and every soft reset
  assign restart_trig  = (main_wr && pwdata[AN_RESTART_BIT]) || soft_rst_trig ||
                         !hw_rst_done_reg;

  assign op_start = {restart_trig, soft_rst_trig};
  assign op_len[OP_SOFT_RESET] = SOFT_RESET_CYCLES;
  assign op_len[OP_AN_RESTART] = AN_RESTART_CYCLES;

  // one timer per self-clearing operation
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_op
      self_clear_timer u_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (op_start[g]),
        .length  (op_len[g]),
        .busy    (op_busy[g]),
        .done    ()
      );
    end
  endgenerate

  // main register readback
  always_comb begin
    main_rd = 16'h0000;
    // self-clearing bits show the running operation
    main_rd[SOFT_RESET_BIT] = op_busy[OP_SOFT_RESET] || op_start[OP_SOFT_RESET];
    main_rd[AN_RESTART_BIT] = op_busy[OP_AN_RESTART] || op_start[OP_AN_RESTART];
    main_rd[LOOPBACK_BIT]   = loopback_reg;
    main_rd[SPEED_LSB_BIT]  = speed_pend_reg[0];
    main_rd[SPEED_MSB_BIT]  = speed_pend_reg[1];
    main_rd[AN_ENABLE_BIT]  = an_en_pend_reg;
    main_rd[POWER_DOWN_BIT] = pd_main_reg;
    main_rd[DUPLEX_BIT]     = duplex_pend_reg;
    // isolate and collision test stay zero
    main_rd[ISOLATE_BIT]    = 1'b0;
    main_rd[COL_TEST_BIT]   = 1'b0;
  end

  // register file next state
  always_comb begin
    loopback_next    = loopback_reg;
    speed_pend_next  = speed_pend_reg;
    duplex_pend_next = duplex_pend_reg;
    an_en_pend_next  = an_en_pend_reg;
    pd_main_next     = pd_main_reg;
    pd_aux_next      = pd_aux_reg;
    lb_speed_next    = lb_speed_reg;
    hw_rst_done_next = 1'b1;
    if (main_wr) begin
      loopback_next    = pwdata[LOOPBACK_BIT];
      // speed bits msb at 6, lsb at 13
      speed_pend_next  = {pwdata[SPEED_MSB_BIT], pwdata[SPEED_LSB_BIT]};
      duplex_pend_next = pwdata[DUPLEX_BIT];
      an_en_pend_next  = pwdata[AN_ENABLE_BIT];
      pd_main_next     = pwdata[POWER_DOWN_BIT];
    end
    if (wr_stb && paddr == LOOPBACK_SPEED_ADDR) begin
      lb_speed_next = pwdata[2:0];
    end
    if (wr_stb && paddr == AUX_POWER_DOWN_ADDR) begin
      pd_aux_next = pwdata[AUX_PD_BIT];
    end
    // soft reset turns loopback off; power down is retained
    if (soft_rst_trig) begin
      loopback_next = LOOPBACK_RST;
    end
    // either bit keeps the port down
    pd_eff_next = pd_main_next || pd_aux_next;
  end

  // active configuration next state
  always_comb begin
    active_next = active_reg;
    // pending values move over only on the three triggers
    if (soft_rst_trig || (main_wr && pwdata[AN_RESTART_BIT])) begin
      active_next.speed     = speed_pend_next;
      active_next.duplex    = duplex_pend_next;
      active_next.an_enable = an_en_pend_next;
    end
    active_next.forced_gig = !active_next.an_enable && (active_next.speed == SPEED_1000);
  end

  // control outputs and data paths
  always_comb begin
    // only the listed pages see the soft reset
    page_rst_next = (op_busy[OP_SOFT_RESET] || soft_rst_trig) ? SOFT_RESET_PAGES : 8'h00;
    sm_reset_next = op_busy[OP_SOFT_RESET] || soft_rst_trig;
    restart_next  = restart_trig;
    pd_out_next   = pd_eff_next;
    // forced gigabit overrides the advertisement registers
    adv_next[0]   = active_next.forced_gig;
    adv_next[1]   = active_next.forced_gig && active_next.duplex;
    adv_next[2]   = active_next.forced_gig && !active_next.duplex;
    // loopback returns mac data and breaks the line link
    link_en_next  = !loopback_next && !pd_eff_next;
    if (loopback_reg) begin
      mac_rx_next  = mac_tx;
      line_tx_next = '0;
    end else begin
      mac_rx_next  = line_rx;
      line_tx_next = mac_tx;
    end
  end

  // apb answer: one wait cycle, then pready with data
  always_comb begin
    pready_next  = psel && penable && !pready_reg;
    prdata_next  = prdata_reg;
    pslverr_next = pready_next && !mapped;
    if (rd_stb) begin
      case (paddr)
        COPPER_MAIN_CONTROL_ADDR: prdata_next = {16'h0000, main_rd};
        // loopback speed field lives apart from the speed bits
        LOOPBACK_SPEED_ADDR:      prdata_next = {29'h0, lb_speed_reg};
        AUX_POWER_DOWN_ADDR:      prdata_next = {29'h0, pd_aux_reg, 2'h0};
        ACTIVE_STATUS_ADDR:       prdata_next = {25'h0, pd_eff_reg, link_en_reg, active_reg};
        default:                  prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      loopback_reg    <= LOOPBACK_RST;
      // speed msb and lsb reset to 1000 mbps
      speed_pend_reg  <= {SPEED_MSB_RST, SPEED_LSB_RST};
      duplex_pend_reg <= DUPLEX_RST;
      an_en_pend_reg  <= AN_ENABLE_RST;
      // power down comes from the straps
      pd_main_reg     <= strap_pd;
      pd_aux_reg      <= 1'b0;
      pd_eff_reg      <= strap_pd;
      lb_speed_reg    <= LB_SPEED_RST;
      hw_rst_done_reg <= 1'b0;
      active_reg      <= '{speed: {SPEED_MSB_RST, SPEED_LSB_RST}, duplex: DUPLEX_RST,
                           an_enable: AN_ENABLE_RST, forced_gig: 1'b0};
      pready_reg      <= 1'b0;
      prdata_reg      <= 32'h0000_0000;
      pslverr_reg     <= 1'b0;
      mac_rx_reg      <= '0;
      line_tx_reg     <= '0;
      link_en_reg     <= 1'b0;
      sm_reset_reg    <= 1'b1;
      page_rst_reg    <= SOFT_RESET_PAGES;
      restart_reg     <= 1'b0;
      pd_out_reg      <= 1'b0;
      adv_reg         <= 3'h0;
    end else begin
      loopback_reg    <= loopback_next;
      speed_pend_reg  <= speed_pend_next;
      duplex_pend_reg <= duplex_pend_next;
      an_en_pend_reg  <= an_en_pend_next;
      pd_main_reg     <= pd_main_next;
      pd_aux_reg      <= pd_aux_next;
      pd_eff_reg      <= pd_eff_next;
      lb_speed_reg    <= lb_speed_next;
      hw_rst_done_reg <= hw_rst_done_next;
      active_reg      <= active_next;
      pready_reg      <= pready_next;
      prdata_reg      <= prdata_next;
      pslverr_reg     <= pslverr_next;
      mac_rx_reg      <= mac_rx_next;
      line_tx_reg     <= line_tx_next;
      link_en_reg     <= link_en_next;
      sm_reset_reg    <= sm_reset_next;
      page_rst_reg    <= page_rst_next;
      restart_reg     <= restart_next;
      pd_out_reg      <= pd_out_next;
      adv_reg         <= adv_next;
    end
  end

  // outputs straight from flops
  assign pready            = pready_reg;
  assign prdata            = prdata_reg;
  assign pslverr           = pslverr_reg;
  assign mac_rx            = mac_rx_reg;
  assign line_tx           = line_tx_reg;
  assign line_link_enable  = link_en_reg;
  assign loopback_speed    = lb_speed_reg;
  assign phy_sm_reset      = sm_reset_reg;
  assign page_reset        = page_rst_reg;
  assign an_restart        = restart_reg;
  assign powered_down      = pd_out_reg;
  assign active_cfg        = active_reg;
  assign adv_override      = adv_reg[0];
  assign adv_gig_full_only = adv_reg[1];
  assign adv_gig_half_only = adv_reg[2];
endmodule // copper_phy_control_register

// *** verification/copper_ctrl_monitor.sv ***
// concurrent checks on the copper main control ports
`timescale 1ns/1ps
module copper_ctrl_monitor (
  input wire logic                         ref_clk,
  input wire logic                         rst_n,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [11:0]                  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  input wire logic [31:0]                  prdata,
  input wire copper_ctrl_pkg::mii_beat_s   mac_tx,
  input wire copper_ctrl_pkg::mii_beat_s   mac_rx,
  input wire copper_ctrl_pkg::mii_beat_s   line_tx,
  input wire logic                         line_link_enable,
  input wire logic                         phy_sm_reset,
  input wire logic [7:0]                   page_reset,
  input wire logic                         an_restart,
  input wire logic                         powered_down,
  input wire copper_ctrl_pkg::active_cfg_s active_cfg,
  input wire logic                         adv_override,
  input wire logic                         adv_gig_full_only,
  input wire logic                         adv_gig_half_only
);
  import copper_ctrl_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // completed access to the control word
  wire acc0 = psel && penable && pready && paddr == COPPER_MAIN_CONTROL_ADDR;
  property p_sr_start;
    acc0 && pwrite && pwdata[15] |=> phy_sm_reset;
  endproperty
  a_sr_start: assert property (p_sr_start) else $error("soft reset not started");
  property p_sr_len;
    $rose(phy_sm_reset) |-> phy_sm_reset[*8] ##[1:20] !phy_sm_reset;
  endproperty
  a_sr_len: assert property (p_sr_len) else $error("soft reset length wrong");
  property p_pages;
    page_reset == (phy_sm_reset ? SOFT_RESET_PAGES : 8'h00);
  endproperty
  a_pages: assert property (p_pages) else $error("page reset mask wrong");
  property p_sr_an;
    $rose(phy_sm_reset) |-> an_restart;
  endproperty
  a_sr_an: assert property (p_sr_an) else $error("no restart on soft reset");
  property p_wake;
    $fell(powered_down) |-> ##[0:3] phy_sm_reset;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without soft reset");
  property p_pd_link;
    powered_down && $past(powered_down) |-> !line_link_enable;
  endproperty
  a_pd_link: assert property (p_pd_link) else $error("link up in power down");
  // two quiet cycles of dropped link outside reset and power down mean loopback
  property p_loop;
    !line_link_enable && !$past(line_link_enable) && !powered_down && !$past(powered_down)
      && !phy_sm_reset |-> mac_rx == $past(mac_tx) && line_tx == '0;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback path wrong");
  property p_ro;
    acc0 && !pwrite |-> prdata[10] == 1'b0 && prdata[7] == 1'b0 && prdata[5:0] == 6'h00;
  endproperty
  a_ro: assert property (p_ro) else $error("inert bits read nonzero");
  property p_defer;
    !(an_restart || $past(an_restart) || phy_sm_reset || $past(phy_sm_reset))
      |-> $stable(active_cfg);
  endproperty
  a_defer: assert property (p_defer) else $error("config changed untriggered");
  property p_gig;
    active_cfg.forced_gig && $stable(active_cfg) |-> adv_override
      && adv_gig_full_only == active_cfg.duplex && adv_gig_half_only == !active_cfg.duplex;
  endproperty
  a_gig: assert property (p_gig) else $error("forced gigabit advert wrong");
endmodule // copper_ctrl_monitor

// *** verification/apb_host_model.sv ***
// apb host model that issues register transfers toward the block
`timescale 1ns/1ps
module apb_host_model (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // setup then access, held until pready is sampled; call right after an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no local limit: only the bench watchdog may end a stalled wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines stop showing the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // apb_host_model

// *** verification/tb.sv ***
// self-checking testbench for the copper main control register
`timescale 1ns/1ps
module tb;
  import copper_ctrl_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, power_down_strap = 1'b0;
  logic [2:0]  mode_strap = 3'h0, loopback_speed;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed = 32'h000134a1;
  mii_beat_s   mac_tx = '0, line_rx = '0, mac_rx, line_tx;
  logic        line_link_enable, phy_sm_reset, an_restart, powered_down;
  logic        adv_override, adv_gig_full_only, adv_gig_half_only;
  logic [7:0]  page_reset;
  active_cfg_s active_cfg;
  int          mismatches = 0, n_tests = 0, n_restart = 0, pend, act, aux;
  copper_phy_control_register u_copper_phy_control_register (.*);
  apb_host_model host (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // random beats on both data inputs, restart pulses counted since reset
  always @(posedge ref_clk) begin
    mac_tx <= mii_beat_s'(9'(rnd()));
    line_rx <= mii_beat_s'(9'(rnd()));
    n_restart <= !rst_n ? 0 : n_restart + int'(an_restart === 1'b1);
  end
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    host.xfer(w, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    acc(1'b0, a, 32'h0, r, e);
    ck(r, exp);
  endtask
  // model: pending bits, applied on soft reset, restart or wake
  task automatic put(input logic [11:0] a, input int v);
    logic [31:0] r;
    logic        e, was, sr;
    was = pend[11] | aux[0];
    if (a == COPPER_MAIN_CONTROL_ADDR) pend = v & 32'h7940;
    else aux = v[2];
    sr = v[15] || (was && !(pend[11] | aux[0]));
    if (sr) pend[14] = 1'b0;
    if (sr || v[9]) act = pend;
    acc(1'b1, a, v, r, e);
    wt(40);
  endtask
  function automatic active_cfg_s ecfg();
    ecfg.speed = {act[6], act[13]};
    ecfg.duplex = act[8];
    ecfg.an_enable = act[12];
    ecfg.forced_gig = !act[12] && {act[6], act[13]} == SPEED_1000;
  endfunction
  task automatic hr(input logic s, input logic [2:0] m);
    power_down_strap <= s;
    mode_strap <= m;
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    aux = 0;
    pend = (s && m[2] == m[1]) ? 32'h1940 : 32'h1140;
    act = pend;
    wt(30);
  endtask
  // hang guard, far beyond the roughly one thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end
  initial begin
    logic [31:0] r, q;
    logic        e;
    logic [2:0]  ls;
    for (int m = 0; m < 8; m++) begin
      r = rnd();
      hr(r[0] || m == 7, 3'(m));
      ck(n_restart, 1);
      ck(powered_down, pend[11]);
      rd(COPPER_MAIN_CONTROL_ADDR, pend);
    end
    // new settings wait in power down until both bits clear
    put(COPPER_MAIN_CONTROL_ADDR, 32'h2800);
    ck(active_cfg, ecfg());
    put(AUX_POWER_DOWN_ADDR, 32'h4);
    put(COPPER_MAIN_CONTROL_ADDR, 32'h2000);
    ck(powered_down, 1'b1);
    ck(active_cfg, ecfg());
    put(AUX_POWER_DOWN_ADDR, 32'h0);
    ck(active_cfg, ecfg());
    ck({powered_down, line_link_enable}, 2'b01);
    ck(n_restart, 2);
    // every speed code and duplex, each written together with a soft reset
    for (int i = 0; i < 8; i++) begin
      put(COPPER_MAIN_CONTROL_ADDR, 32'h8000 | i[0] << 13 | i[1] << 6 | i[2] << 8);
      ck(active_cfg, ecfg());
      ck({adv_override, adv_gig_full_only, adv_gig_half_only},
         {i[1:0] == 2, i[1:0] == 2 && i[2], i[1:0] == 2 && !i[2]});
    end
    pend = 32'h1140;
    act = pend;
    acc(1'b1, COPPER_MAIN_CONTROL_ADDR, 32'h9140, r, e);
    acc(1'b0, COPPER_MAIN_CONTROL_ADDR, 32'h0, r, e);
    wt(0);
    ck(r[15], 1'b1);
    ck({phy_sm_reset, page_reset}, 9'h1ad);
    wt(40);
    rd(COPPER_MAIN_CONTROL_ADDR, pend);
    r = rnd();
    ls = r[2:0];
    acc(1'b1, LOOPBACK_SPEED_ADDR, 32'(ls), r, e);
    // loopback on then off, data path followed beat by beat
    for (int lb = 1; lb >= 0; lb--) begin
      put(COPPER_MAIN_CONTROL_ADDR, lb ? 32'h5140 : 32'h1140);
      ck(loopback_speed, ls);
      ck(line_link_enable, lb == 0);
      repeat (8) begin
        r = lb ? mac_tx : line_rx;
        q = mac_tx;
        wt(1);
        ck(mac_rx, r);
        ck(line_tx, lb ? 32'h0 : q);
      end
    end
    acc(1'b1, 12'h010, 32'hffff, r, e);
    ck(e, 1'b1);
    acc(1'b0, 12'h010, 32'h0, r, e);
    ck({e, r[30:0]}, 32'h80000000);
    put(COPPER_MAIN_CONTROL_ADDR, 32'h14bf);
    rd(COPPER_MAIN_CONTROL_ADDR, pend);
    ck(line_link_enable, 1'b1);
    // a restart write alone moves the pending word over
    put(COPPER_MAIN_CONTROL_ADDR, 32'h1200);
    ck(active_cfg, ecfg());
    ck(n_restart, 12);
    rd(ACTIVE_STATUS_ADDR, 32'({2'b01, ecfg()}));
    rd(LOOPBACK_SPEED_ADDR, 32'(ls));
    test_done();
  end
endmodule // tb
bind copper_phy_control_register copper_ctrl_monitor u_copper_ctrl_monitor (.*);
